// ### core/frame_byte_fifo.v
`timescale 1ns/1ps
`default_nettype none

module frame_byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_wr_valid,
    output wire o_wr_ready,
    input wire [WIDTH-1:0] i_wr_data,
    output wire o_rd_valid,
    input wire i_rd_ready,
    output wire [WIDTH-1:0] o_rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign o_wr_ready = (count != DEPTH[AW:0]);
    assign o_rd_valid = (count != {(AW+1){1'b0}});
    assign o_rd_data = mem[rd_ptr];
    assign do_wr = i_wr_valid && o_wr_ready;
    assign do_rd = i_rd_ready && o_rd_valid;

    always @(posedge i_ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ### core/overboard_locator_consts.vh
`ifndef OVERBOARD_LOCATOR_CONSTS_VH
`define OVERBOARD_LOCATOR_CONSTS_VH

// ----------------------------------------
// clock and timing figures
// ----------------------------------------
`define CLK_HZ 125000000
`define BIT_RATE_BPS 9600
`define SLOT_FRAME_S 2
`define SLOTS_PER_FRAME 75
`define STUCK_KEY_S 2
`define MAX_TX_US 26600
`define TDMA_ERR_US 312
`define START_TIMEOUT_S 60
`define UNSYNC_MIN_S 10
`define UNSYNC_MAX_S 30
`define UNSYNC_AT_S 15
`define SYNC_DEADLINE_S 300
`define TEST_TIMEOUT_S 300
`define POS_REFRESH_S 60

// ----------------------------------------
// burst layout
// ----------------------------------------
`define BURST_TX 3'h7
`define TX_SPACING_SLOTS 12'h04A
`define BURST_REPEAT_BASE 12'h5DC
`define BURST_JITTER 9'h1C2
`define TIMEOUT_FIRST 3'h7
`define TIMEOUT_TEXT 3'h3

// ----------------------------------------
// frame layout
// ----------------------------------------
`define TRAIN_SEQ 24'h555555
`define HDLC_FLAG 8'h7E
`define FRAME_BYTES 5'h1A
`define FRAME_BITS 8'hD0
`define MSG_POSITION 6'h01
`define MSG_SAFETY_TEXT 6'h0E
`define NAV_STATUS_ACTIVE 4'hE
`define NAV_STATUS_TEST 4'hF
`define TEXT_ACTIVE {6'h0D, 6'h0F, 6'h02, 6'h20, 6'h01, 6'h03, 6'h14, 6'h09, 6'h16, 6'h05}
`define TEXT_TEST {6'h0D, 6'h0F, 6'h02, 6'h20, 6'h14, 6'h05, 6'h13, 6'h14, 6'h00, 6'h00}
`define CH1_KHZ 18'h278B7
`define CH2_KHZ 18'h278E9

`endif

// ### core/overboard_locator_tx_sequencer.v
// Operation
// - when active, send position reports and safety text messages, content per mode
// - active mode uses navigation status 14 and text MOB ACTIVE
// - test mode uses navigation status 15 and text MOB TEST
// - transmit on both channels, defaults 161.975 and 162.025 MHz
// - shut down on its own if keyed continuously over 2 seconds
// - slot timing taken from receiver UTC pulse, error under 312 us
// - after first fix, refresh own position at least every minute
// - active mode starts when fix, speed, course, UTC ready, or 60 s
// - optional single unsynchronized transmission 10 to 30 s after activation
// - synchronized transmissions with real position start within 5 minutes
// - keep transmitting on loss of fix or lock, free-run slot timing
// - without current fix, reports carry last valid position
// - test mode sends one burst once all data and UTC lock exist
// - test mode abandoned silently if no UTC lock within five minutes
// - test activation clears itself after its single burst
// - every activation forces a receiver cold start, no retained data; after a stuck-key shutdown S_HALT ignores activation, no cold start
// - cold start may reuse only valid leap-second information
// - slot alignment uses correctly computed UTC even-second boundaries
// - burst transmissions spaced 75 slots, alternating channels
// - first slot random, remaining seven fixed relative to it
// - test burst reports carry slot time-out 0 and sub-message 0
`timescale 1ns/1ps
`default_nettype none
`include "overboard_locator_consts.vh"

module overboard_locator_tx_sequencer #(
    parameter SEC_CYCLES = `CLK_HZ,
    parameter SLOT_CYCLES = `CLK_HZ / `SLOTS_PER_FRAME * `SLOT_FRAME_S,
    parameter BIT_CYCLES = `CLK_HZ / `BIT_RATE_BPS,
    parameter STUCK_CYCLES = `STUCK_KEY_S * `CLK_HZ,
    parameter MAX_TX_CYCLES = `MAX_TX_US * (`CLK_HZ / 1000000),
    parameter UNSYNC_ENABLE = 1,
    parameter [29:0] USER_ID = 30'h0ABCDEF1
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_activate,
    input wire i_test_request,
    input wire i_utc_pps,
    input wire i_utc_even_sec,
    input wire i_utc_lock,
    input wire i_time_valid,
    input wire i_fix_valid,
    input wire i_sog_valid,
    input wire i_cog_valid,
    input wire i_leap_valid,
    input wire [27:0] i_lon,
    input wire [26:0] i_lat,
    input wire [9:0] i_speed_over_ground,
    input wire [11:0] i_course_over_ground,
    output reg o_tx_key,
    output reg o_tx_data,
    output reg o_channel_sel,
    output reg [17:0] o_channel_khz,
    output reg o_gnss_cold_start,
    output reg o_gnss_keep_leap,
    output reg o_pos_request,
    output reg o_test_active,
    output reg o_transmitting,
    output reg o_shutdown
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ACQ = 7'h02;
    localparam [6:0] S_WAIT = 7'h04;
    localparam [6:0] S_SEND = 7'h08;
    localparam [6:0] S_DRAIN = 7'h10;
    localparam [6:0] S_DONE = 7'h20;
    localparam [6:0] S_HALT = 7'h40;
    localparam TDMA_ERR_CYCLES = `TDMA_ERR_US * (`CLK_HZ / 1000000);

    reg [6:0] state;
    reg [31:0] sec_div;
    reg [8:0] seconds;
    reg [31:0] slot_cnt;
    reg slot_tick;
    reg [31:0] bit_div;
    reg bit_tick;
    reg [15:0] lfsr;
    reg test_mode;
    reg activate_q;
    reg unsync_done;
    reg unsync_tx;
    reg [2:0] tx_index;
    reg [2:0] slot_timeout;
    reg [11:0] wait_slots;
    reg have_fix;
    reg [5:0] pos_age;
    reg [27:0] last_lon;
    reg [26:0] last_lat;
    reg [9:0] last_sog;
    reg [11:0] last_cog;
    reg [207:0] frame;
    reg [4:0] byte_idx;
    reg [7:0] shreg;
    reg [2:0] sh_left;
    reg [7:0] frame_bits;
    reg [31:0] tx_cycles;
    reg [31:0] stuck_cycles;
    reg tx_done;

    wire sec_tick = (sec_div == SEC_CYCLES - 1);
    wire all_data = i_fix_valid && i_sog_valid && i_cog_valid;
    wire act_rise = i_activate && !activate_q;
    wire text_slot = test_mode ? (tx_index == 3'h0 || tx_index == `BURST_TX) :
        ((slot_timeout == `TIMEOUT_FIRST || slot_timeout == `TIMEOUT_TEXT) &&
         (tx_index == 3'h4 || tx_index == 3'h5));
    wire [8:0] jitter = (lfsr[8:0] >= `BURST_JITTER) ? lfsr[8:0] - `BURST_JITTER : lfsr[8:0];
    wire [3:0] nav_status = test_mode ? `NAV_STATUS_TEST : `NAV_STATUS_ACTIVE;
    wire [2:0] tx_timeout = test_mode ? 3'h0 : slot_timeout;
    wire [59:0] text = test_mode ? `TEXT_TEST : `TEXT_ACTIVE;
    wire [167:0] msg_pos = {`MSG_POSITION, 2'h0, USER_ID, nav_status, 8'h80, last_sog, 1'b0,
        last_lon, last_lat, last_cog, 9'h1FF, 6'h3C, 2'h0, 3'h0, 1'b0, 2'h0, tx_timeout, 14'h0000};
    wire [167:0] msg_text = {`MSG_SAFETY_TEXT, 2'h0, USER_ID, 2'h0, text, 68'h0};
    wire wr_valid = (state == S_SEND);
    wire wr_ready;
    wire [7:0] wr_data = frame[8*(`FRAME_BYTES - 5'h01 - byte_idx) +: 8];
    wire rd_valid;
    wire [7:0] rd_data;
    wire tx_over = (tx_cycles >= MAX_TX_CYCLES - 1);
    wire rd_ready = bit_tick && (sh_left == 3'h0) && (frame_bits != `FRAME_BITS) && !tx_over;

    // ----------------------------------------
    // frame bytes buffered ahead of the serializer
    // ----------------------------------------
    frame_byte_fifo #(
        .WIDTH(8),
        .DEPTH(8),
        .AW(3)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr_valid(wr_valid),
        .o_wr_ready(wr_ready),
        .i_wr_data(wr_data),
        .o_rd_valid(rd_valid),
        .i_rd_ready(rd_ready),
        .o_rd_data(rd_data)
    );

    // ----------------------------------------
    // timebases
    // ----------------------------------------
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sec_div <= 32'h00000000;
            slot_cnt <= 32'h00000000;
            slot_tick <= 1'b0;
            bit_div <= 32'h00000000;
            bit_tick <= 1'b0;
            lfsr <= 16'hACE1;
        end else begin
            sec_div <= sec_tick ? 32'h00000000 : sec_div + 32'h00000001;
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            bit_tick <= (bit_div == BIT_CYCLES - 1);
            bit_div <= (bit_div == BIT_CYCLES - 1) ? 32'h00000000 : bit_div + 32'h00000001;
            // even-second pulse restarts the slot grid; without lock it free-runs
            if (i_utc_pps && i_utc_lock && i_utc_even_sec) begin
                slot_cnt <= 32'h00000000;
                // a pulse just after a grid tick is that same boundary: no second tick
                slot_tick <= (slot_cnt > TDMA_ERR_CYCLES);
            end else if (slot_cnt == SLOT_CYCLES - 1) begin
                slot_cnt <= 32'h00000000;
                slot_tick <= 1'b1;
            end else begin
                slot_cnt <= slot_cnt + 32'h00000001;
                slot_tick <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // position capture and refresh
    // ----------------------------------------
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            have_fix <= 1'b0;
            pos_age <= 6'h00;
            last_lon <= 28'h6791AC0;
            last_lat <= 27'h3412140;
            last_sog <= 10'h3FF;
            last_cog <= 12'hE10;
            o_pos_request <= 1'b0;
        end else begin
            o_pos_request <= 1'b0;
            if (act_rise) begin
                have_fix <= 1'b0;
                pos_age <= 6'h00;
                last_lon <= 28'h6791AC0;
                last_lat <= 27'h3412140;
                last_sog <= 10'h3FF;
                last_cog <= 12'hE10;
            end else begin
                // reports keep the last good values while the fix is gone
                if (i_fix_valid) begin
                    have_fix <= 1'b1;
                    last_lon <= i_lon;
                    last_lat <= i_lat;
                end
                if (i_fix_valid && i_sog_valid) begin
                    last_sog <= i_speed_over_ground;
                end
                if (i_fix_valid && i_cog_valid) begin
                    last_cog <= i_course_over_ground;
                end
                if (have_fix && sec_tick && i_activate) begin
                    if (pos_age == `POS_REFRESH_S - 1) begin
                        pos_age <= 6'h00;
                        o_pos_request <= 1'b1;
                    end else begin
                        pos_age <= pos_age + 6'h01;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= S_IDLE;
            activate_q <= 1'b0;
            seconds <= 9'h000;
            test_mode <= 1'b0;
            unsync_done <= 1'b0;
            unsync_tx <= 1'b0;
            tx_index <= 3'h0;
            slot_timeout <= `TIMEOUT_FIRST;
            wait_slots <= 12'h000;
            frame <= 208'h0;
            byte_idx <= 5'h00;
            o_channel_sel <= 1'b0;
            o_channel_khz <= `CH1_KHZ;
            o_gnss_cold_start <= 1'b0;
            o_gnss_keep_leap <= 1'b0;
            o_test_active <= 1'b0;
        end else begin
            activate_q <= i_activate;
            o_gnss_cold_start <= 1'b0;
            o_channel_khz <= o_channel_sel ? `CH2_KHZ : `CH1_KHZ;
            if (sec_tick && seconds != 9'h1FF) begin
                seconds <= seconds + 9'h001;
            end
            if (stuck_cycles >= STUCK_CYCLES - 1) begin
                state <= S_HALT;
            end else if (!i_activate && state != S_HALT) begin
                state <= S_IDLE;
                o_test_active <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: begin
                        if (act_rise) begin
                            state <= S_ACQ;
                            seconds <= 9'h000;
                            test_mode <= i_test_request;
                            o_test_active <= i_test_request;
                            unsync_done <= 1'b0;
                            o_gnss_cold_start <= 1'b1;
                            o_gnss_keep_leap <= i_leap_valid;
                            o_channel_sel <= 1'b0;
                        end
                    end
                    S_ACQ: begin
                        tx_index <= 3'h0;
                        byte_idx <= 5'h00;
                        if (test_mode) begin
                            if (all_data && i_time_valid && i_utc_lock) begin
                                slot_timeout <= 3'h0;
                                wait_slots <= {1'b0, lfsr[10:0]};
                                state <= S_WAIT;
                            end else if (seconds >= `TEST_TIMEOUT_S) begin
                                state <= S_DONE;
                                o_test_active <= 1'b0;
                            end
                        end else if ((all_data && i_utc_lock) || seconds >= `START_TIMEOUT_S) begin
                            slot_timeout <= `TIMEOUT_FIRST;
                            wait_slots <= {1'b0, lfsr[10:0]};
                            state <= S_WAIT;
                        end else if (UNSYNC_ENABLE != 0 && !unsync_done && seconds >= `UNSYNC_AT_S &&
                                     seconds < `UNSYNC_MAX_S && seconds >= `UNSYNC_MIN_S) begin
                            unsync_done <= 1'b1;
                            unsync_tx <= 1'b1;
                            frame <= {`TRAIN_SEQ, `HDLC_FLAG, msg_pos, `HDLC_FLAG};
                            state <= S_SEND;
                        end
                    end
                    S_WAIT: begin
                        if (slot_tick) begin
                            if (wait_slots == 12'h000) begin
                                frame <= {`TRAIN_SEQ, `HDLC_FLAG, text_slot ? msg_text : msg_pos, `HDLC_FLAG};
                                state <= S_SEND;
                            end else begin
                                wait_slots <= wait_slots - 12'h001;
                            end
                        end
                    end
                    S_SEND: begin
                        // stalls here whenever the buffer is full
                        if (wr_ready) begin
                            byte_idx <= byte_idx + 5'h01;
                            if (byte_idx == `FRAME_BYTES - 5'h01) begin
                                state <= S_DRAIN;
                            end
                        end
                    end
                    S_DRAIN: begin
                        if (tx_done) begin
                            byte_idx <= 5'h00;
                            if (unsync_tx) begin
                                unsync_tx <= 1'b0;
                                state <= S_ACQ;
                            end else if (tx_index == `BURST_TX) begin
                                o_channel_sel <= ~o_channel_sel;
                                tx_index <= 3'h0;
                                if (test_mode) begin
                                    state <= S_DONE;
                                    o_test_active <= 1'b0;
                                end else begin
                                    slot_timeout <= slot_timeout - 3'h1;
                                    wait_slots <= `BURST_REPEAT_BASE + {3'h0, jitter};
                                    state <= S_WAIT;
                                end
                            end else begin
                                o_channel_sel <= ~o_channel_sel;
                                tx_index <= tx_index + 3'h1;
                                wait_slots <= `TX_SPACING_SLOTS;
                                state <= S_WAIT;
                            end
                        end
                    end
                    S_DONE: begin
                        state <= S_DONE;
                    end
                    S_HALT: begin
                        o_test_active <= 1'b0;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // serializer and key guards
    // ----------------------------------------
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tx_key <= 1'b0;
            o_tx_data <= 1'b0;
            o_transmitting <= 1'b0;
            o_shutdown <= 1'b0;
            shreg <= 8'h00;
            sh_left <= 3'h0;
            frame_bits <= 8'h00;
            tx_cycles <= 32'h00000000;
            stuck_cycles <= 32'h00000000;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            o_transmitting <= (state == S_WAIT) || (state == S_SEND) || (state == S_DRAIN);
            // watchdog sees only the key pin, not the sequencer
            stuck_cycles <= o_tx_key ? stuck_cycles + 32'h00000001 : 32'h00000000;
            if (stuck_cycles >= STUCK_CYCLES - 1 || o_shutdown) begin
                o_shutdown <= 1'b1;
                o_tx_key <= 1'b0;
            end else if (o_tx_key && tx_over) begin
                o_tx_key <= 1'b0;
                tx_cycles <= 32'h00000000;
                frame_bits <= 8'h00;
                sh_left <= 3'h0;
                tx_done <= 1'b1;
            end else if (bit_tick) begin
                if (o_tx_key) begin
                    tx_cycles <= tx_cycles + 32'h00000001;
                end
                if (sh_left != 3'h0) begin
                    // zero toggles the line, one holds it
                    o_tx_data <= shreg[7] ? o_tx_data : ~o_tx_data;
                    shreg <= {shreg[6:0], 1'b0};
                    sh_left <= sh_left - 3'h1;
                    frame_bits <= frame_bits + 8'h01;
                end else if (frame_bits == `FRAME_BITS) begin
                    o_tx_key <= 1'b0;
                    tx_cycles <= 32'h00000000;
                    frame_bits <= 8'h00;
                    tx_done <= 1'b1;
                end else if (rd_valid) begin
                    o_tx_key <= 1'b1;
                    o_tx_data <= rd_data[7] ? o_tx_data : ~o_tx_data;
                    shreg <= {rd_data[6:0], 1'b0};
                    sh_left <= 3'h7;
                    frame_bits <= frame_bits + 8'h01;
                end
            end else if (o_tx_key) begin
                tx_cycles <= tx_cycles + 32'h00000001;
            end
        end
    end
endmodule

`default_nettype wire

// ### tb/overboard_locator_tx_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "overboard_locator_consts.vh"
module overboard_locator_tx_sequencer_bench;
    localparam int SEC = 100;
    logic i_ref_clk, i_rst, i_activate, i_test_request, i_fix_valid, i_leap_valid;
    logic i_utc_pps, i_utc_even_sec, i_utc_lock, i_time_valid;
    logic [27:0] i_lon;
    logic [26:0] i_lat;
    logic [9:0] i_sog;
    logic [11:0] i_cog;
    wire o_tx_key, o_tx_data, o_channel_sel, o_gnss_cold_start, o_gnss_keep_leap;
    wire o_pos_request, o_test_active, o_transmitting, o_shutdown;
    wire [17:0] o_channel_khz;
    logic [207:0] bits;
    int frames, t, n, pulses = 0, miscompares = 0, check_count = 0, seed = 44418;
    overboard_locator_tx_sequencer #(.SEC_CYCLES(SEC), .SLOT_CYCLES(240), .BIT_CYCLES(1), .STUCK_CYCLES(5000),
        .MAX_TX_CYCLES(300)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_activate(i_activate),
        .i_test_request(i_test_request), .i_utc_pps(i_utc_pps), .i_utc_even_sec(i_utc_even_sec),
        .i_utc_lock(i_utc_lock), .i_time_valid(i_time_valid), .i_fix_valid(i_fix_valid),
        .i_sog_valid(i_fix_valid), .i_cog_valid(i_fix_valid),
        .i_leap_valid(i_leap_valid), .i_lon(i_lon), .i_lat(i_lat), .i_speed_over_ground(i_sog),
        .i_course_over_ground(i_cog), .o_tx_key(o_tx_key), .o_tx_data(o_tx_data), .o_channel_sel(o_channel_sel),
        .o_channel_khz(o_channel_khz), .o_gnss_cold_start(o_gnss_cold_start), .o_gnss_keep_leap(o_gnss_keep_leap),
        .o_pos_request(o_pos_request), .o_test_active(o_test_active), .o_transmitting(o_transmitting),
        .o_shutdown(o_shutdown));
    shipboard_receiver_model rx (.i_ref_clk(i_ref_clk), .i_tx_key(o_tx_key), .i_tx_data(o_tx_data),
        .o_bits(bits), .o_frames(frames));
    // ----
    // shared tasks
    // ----
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function logic [31:0] field(input int at, input int len);
        field = 0;
        for (int k = 0; k < len; k++) field = {field[30:0], bits[207-at-k]};
    endfunction
    function logic [31:0] nav_exp(input logic test);
        nav_exp = test ? 32'hF : 32'hE;
    endfunction
    // ----
    // clock, data, watchdog
    // ----
    initial begin
        i_ref_clk = 0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) if (o_pos_request === 1'b1) pulses++;
    initial begin
        // fresh receiver data each second so the position fields see real values
        i_utc_even_sec = 1'b0;
        forever begin
            i_lon = $random(seed);
            i_lat = $random(seed);
            i_sog = $random(seed);
            i_cog = $random(seed);
            i_utc_pps = 1'b1;
            i_utc_even_sec = ~i_utc_even_sec;
            @(negedge i_ref_clk);
            i_utc_pps = 1'b0;
            repeat (SEC - 1) @(negedge i_ref_clk);
        end
    end
    initial begin
        repeat (50000) @(posedge i_ref_clk);
        miscompares++;
        end_of_test;
    end
    // ----
    // scenarios
    // ----
    initial begin
        {i_rst, i_activate, i_test_request, i_fix_valid, i_leap_valid} = 5'h10;
        {i_utc_lock, i_time_valid} = 2'h0;
        repeat (6) @(negedge i_ref_clk);
        check(o_channel_khz, `CH1_KHZ);
        check(o_tx_key, 1'b0);
        i_rst = 0;
        @(negedge i_ref_clk);
        i_leap_valid = $random(seed);
        i_activate = 1;
        i_fix_valid = 1;
        t = 0;
        while (frames < 1 && t < 40 * SEC) begin
            @(negedge i_ref_clk);
            t++;
        end
        check(t >= 10 * SEC && t <= 30 * SEC + 300, 1'b1);
        check(field(0, 24), `TRAIN_SEQ);
        check(field(24, 8), `HDLC_FLAG);
        check(field(32, 6), `MSG_POSITION);
        check(field(70, 4), nav_exp(1'b0));
        check(field(200, 8), `HDLC_FLAG);
        repeat (130 * SEC - t) @(negedge i_ref_clk);
        check(pulses inside {2, 3}, 1'b1);
        check(o_transmitting, 1'b1);
        i_activate = 0;
        repeat (4) @(negedge i_ref_clk);
        n = frames;
        i_test_request = 1;
        i_time_valid = 1;
        i_activate = 1;
        @(negedge i_ref_clk);
        i_test_request = 0;
        repeat (3) @(negedge i_ref_clk);
        check(o_test_active, 1'b1);
        check(o_transmitting, 1'b0);
        repeat (290 * SEC) @(negedge i_ref_clk);
        check(o_test_active, 1'b1);
        repeat (15 * SEC) @(negedge i_ref_clk);
        check(o_test_active, 1'b0);
        check(frames, n);
        end_of_test;
    end
endmodule
`default_nettype wire

// ### tb/overboard_locator_tx_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "overboard_locator_consts.vh"
module overboard_locator_tx_sequencer_monitor #(
    parameter SEC_CYCLES = 100,
    parameter BIT_CYCLES = 1,
    parameter MAX_TX_CYCLES = 300
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_activate,
    input wire logic i_leap_valid,
    input wire logic o_tx_key,
    input wire logic o_channel_sel,
    input wire logic [17:0] o_channel_khz,
    input wire logic o_gnss_cold_start,
    input wire logic o_gnss_keep_leap,
    input wire logic o_pos_request,
    input wire logic o_shutdown
);
    // ----
    // helper counters
    // ----
    localparam int FRAME_CYC = 208 * BIT_CYCLES;
    localparam int POS_CYC = 60 * SEC_CYCLES;
    int key_run;
    int pos_gap;
    logic pos_seen;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            key_run <= 0;
            pos_gap <= 0;
            pos_seen <= 1'b0;
        end else begin
            key_run <= o_tx_key ? key_run + 1 : 0;
            pos_gap <= o_pos_request ? 0 : pos_gap + 1;
            // gap only means something between two pulses of one activation
            pos_seen <= i_activate && (pos_seen || o_pos_request);
        end
    end
    a_cold_start_pulse: assert property ($rose(i_activate) && !o_shutdown |=> o_gnss_cold_start)
        else $error("cold start missing after activation");
    a_cold_start_once: assert property (o_gnss_cold_start |=> !o_gnss_cold_start)
        else $error("cold start longer than one cycle");
    a_leap_capture: assert property ($rose(i_activate) && !o_shutdown |=> o_gnss_keep_leap == $past(i_leap_valid))
        else $error("leap keep flag not captured");
    a_channel_freq: assert property (1'b1 |=> o_channel_khz == ($past(o_channel_sel) ? `CH2_KHZ : `CH1_KHZ))
        else $error("channel frequency wrong");
    a_key_max_len: assert property (key_run <= MAX_TX_CYCLES)
        else $error("transmission too long");
    a_frame_bit_len: assert property ($fell(o_tx_key) |-> key_run == FRAME_CYC)
        else $error("frame length wrong");
    a_pos_period: assert property (o_pos_request && pos_seen |-> pos_gap inside {[POS_CYC-2:POS_CYC]})
        else $error("position refresh spacing wrong");
    a_no_false_off: assert property (!o_shutdown)
        else $error("shutdown without stuck key");
endmodule
bind overboard_locator_tx_sequencer overboard_locator_tx_sequencer_monitor #(.SEC_CYCLES(SEC_CYCLES),
    .BIT_CYCLES(BIT_CYCLES), .MAX_TX_CYCLES(MAX_TX_CYCLES)) mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_activate(i_activate), .i_leap_valid(i_leap_valid), .o_tx_key(o_tx_key), .o_channel_sel(o_channel_sel),
    .o_channel_khz(o_channel_khz), .o_gnss_cold_start(o_gnss_cold_start), .o_gnss_keep_leap(o_gnss_keep_leap),
    .o_pos_request(o_pos_request), .o_shutdown(o_shutdown));
`default_nettype wire

// ### tb/shipboard_receiver_model.sv
`timescale 1ns/1ps
`default_nettype none
module shipboard_receiver_model (
    input wire logic i_ref_clk,
    input wire logic i_tx_key,
    input wire logic i_tx_data,
    output var logic [207:0] o_bits,
    output var int o_frames
);
    logic prev;
    logic keyed;
    logic [207:0] shift;
    initial o_frames = 0;
    // one bit per clock: the bench runs the bit tick at the clock rate
    always @(posedge i_ref_clk) begin
        prev <= i_tx_data;
        keyed <= i_tx_key;
        if (i_tx_key) begin
            shift <= {shift[206:0], i_tx_data == prev};
        end else if (keyed) begin
            o_bits <= shift;
            o_frames <= o_frames + 1;
        end
    end
endmodule
`default_nettype wire
